// File: verilog/tcai_alarm_integrator.v
// AHB-Lite T1 carrier failure alarm integrator: windowed detection, integration and interrupts.
`timescale 1ns/1ps
`include "tcai_map.vh"

// Contract
// RL1: Format bit selects extended or standard yellow.
// RL2: Software writes zero to reserved configuration bits.
// RL3: Software keeps production test bit at zero.
// RL4: Quick mode clears red within 120 ms.
// RL5: Quick mode clears all-ones within 180 ms.
// RL6: Otherwise clear with parameterised standard timing.
// RL7: Independent interrupt enables per alarm.
// RL8: Alarm toggle sets its interrupt flag.
// RL9: Status read clears flags and interrupt.
// RL10: Low status bits show live alarm states.
// RL11: Red detect when out-of-frame in 40 ms.
// RL12: Standard yellow: second bit nonzero at most 16.
// RL13: Extended yellow: eight clean yellow codes per window.
// RL14: All-ones: whole-window out-of-frame, at most 126 ones.
// RL15: Interrupt stays high until status read.
// RL16: Alarms integrate over windows, parameterised set timing.
module tcai_alarm_integrator #(
  parameter WIN_W = 22,
  parameter WIN40_CYC = `TCAI_WIN40_MS * `TCAI_CLK_KHZ,
  parameter WIN60_CYC = `TCAI_WIN60_MS * `TCAI_CLK_KHZ,
  parameter INT_W = 4,
  parameter [INT_W-1:0] RED_SET_WIN = 4'h3,
  parameter [INT_W-1:0] RED_CLR_WIN = 4'h6,
  parameter [INT_W-1:0] YEL_SET_WIN = 4'h2,
  parameter [INT_W-1:0] YEL_CLR_WIN = 4'h2,
  parameter [INT_W-1:0] AIS_SET_WIN = 4'h3,
  parameter [INT_W-1:0] AIS_CLR_WIN = 4'h6
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_resetn,
  // AHB-Lite slave port.
  input wire i_hsel,
  input wire [7:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // Receive framer indications, synchronous to i_sys_clk.
  input wire i_out_of_frame,
  input wire i_pcm_valid,
  input wire i_pcm_bit,
  input wire i_chan_bit2_valid,
  input wire i_chan_bit2,
  input wire i_yellow_code_ok,
  // Alarm outputs.
  output wire o_remote_alarm_state,
  output wire o_frame_loss_alarm_state,
  output wire o_all_ones_alarm_state,
  output reg o_irq
);

  // Software registers.
  reg [7:0] cfg_q;
  reg [7:0] ena_q;
  reg [2:0] flag_q;
  reg [2:0] det_q;
  reg [2:0] prev_q;

  // AHB data-phase state.
  reg wr_pend_q;
  reg [5:0] wr_idx_q;

  // Window counters and accumulators.
  reg [WIN_W-1:0] cnt40_q;
  reg [WIN_W-1:0] cnt60_q;
  reg oof40_q;
  reg [4:0] bit2_cnt_q;
  reg [3:0] code_cnt_q;
  reg oof_all_q;
  reg [6:0] ones_cnt_q;

  wire addr_act;
  wire rd_act;
  wire [5:0] rd_idx;
  wire sts_read;
  wire fmt_ext;
  wire quick;
  wire accelerated_test_bit;
  wire [2:0] irq_en;
  wire [WIN_W-1:0] term40;
  wire [WIN_W-1:0] term60;
  wire end40;
  wire end60;
  wire [4:0] bit2_nx;
  wire [3:0] code_nx;
  wire [6:0] ones_nx;
  wire oof40_nx;
  wire oof_all_nx;
  wire red_det;
  wire yel_sf;
  wire yel_esf;
  wire yel_det;
  wire ais_det;
  wire [2:0] state;
  wire [2:0] change;
  wire [2:0] flag_d;
  wire [INT_W-1:0] red_clr;
  wire [INT_W-1:0] ais_clr;
  wire [7:0] sts_view;
  reg [7:0] rd_byte;

  localparam [WIN_W-1:0] W40 = WIN40_CYC[WIN_W-1:0];
  localparam [WIN_W-1:0] W60 = WIN60_CYC[WIN_W-1:0];
  localparam [WIN_W-1:0] ONE_W = {{(WIN_W-1){1'b0}}, 1'b1};

  // Configuration fields.
  assign fmt_ext = cfg_q[`TCAI_CFG_FMT];
  assign quick = ena_q[`TCAI_ENA_QUICK];
  assign accelerated_test_bit = ena_q[`TCAI_ENA_ACCELERATED_TEST_BIT];
  assign irq_en = ena_q[`TCAI_ENA_IRQ_HI:`TCAI_ENA_IRQ_LO];

  // Production test shortens both windows; normal operation expects it clear.
  assign term40 = (accelerated_test_bit ? (W40 >> `TCAI_ACCELERATED_TEST_BIT_SHIFT) : W40) - ONE_W; // RL3
  assign term60 = (accelerated_test_bit ? (W60 >> `TCAI_ACCELERATED_TEST_BIT_SHIFT) : W60) - ONE_W;
  assign end40 = (cnt40_q >= term40);
  assign end60 = (cnt60_q >= term60);

  // Free-running window timers; each restarts after its terminal count.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt40_q <= {WIN_W{1'b0}};
      cnt60_q <= {WIN_W{1'b0}};
    end else begin
      cnt40_q <= end40 ? {WIN_W{1'b0}} : cnt40_q + ONE_W;
      cnt60_q <= end60 ? {WIN_W{1'b0}} : cnt60_q + ONE_W;
    end
  end

  // Next accumulator values include the current cycle, so the last sample of a window counts.
  // Counters saturate at their all-ones value, above their thresholds, to keep them narrow.
  assign oof40_nx = oof40_q | i_out_of_frame;
  assign bit2_nx = (i_chan_bit2_valid && i_chan_bit2 && bit2_cnt_q != 5'h1F) ? bit2_cnt_q + 5'h01 : bit2_cnt_q;
  assign code_nx = (i_yellow_code_ok && code_cnt_q != 4'hF) ? code_cnt_q + 4'h1 : code_cnt_q;
  assign oof_all_nx = oof_all_q & i_out_of_frame;
  assign ones_nx = (i_pcm_valid && i_pcm_bit && ones_cnt_q != 7'h7F) ? ones_cnt_q + 7'h01 : ones_cnt_q;

  // Window verdicts, meaningful in the cycle of the window end.
  assign red_det = oof40_nx; // RL11
  assign yel_sf = (bit2_nx <= `TCAI_SF_YEL_MAX); // RL12
  assign yel_esf = (code_nx >= `TCAI_ESF_YEL_MIN); // RL13
  assign yel_det = fmt_ext ? yel_esf : yel_sf; // RL1
  assign ais_det = oof_all_nx && (ones_nx <= `TCAI_AIS_ONES_MAX); // RL14

  // 40 ms accumulators for red and yellow detection.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      oof40_q <= 1'b0;
      bit2_cnt_q <= 5'h00;
      code_cnt_q <= 4'h0;
    end else if (end40) begin
      oof40_q <= 1'b0;
      bit2_cnt_q <= 5'h00;
      code_cnt_q <= 4'h0;
    end else begin
      oof40_q <= oof40_nx;
      bit2_cnt_q <= bit2_nx;
      code_cnt_q <= code_nx;
    end
  end

  // 60 ms accumulators for all-ones detection; out-of-frame must hold every cycle.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      oof_all_q <= 1'b1;
      ones_cnt_q <= 7'h00;
    end else if (end60) begin
      oof_all_q <= 1'b1;
      ones_cnt_q <= 7'h00;
    end else begin
      oof_all_q <= oof_all_nx;
      ones_cnt_q <= ones_nx;
    end
  end

  // Detection status holds the verdict of the most recent completed window.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      det_q <= 3'h0;
    end else begin
      if (end40) begin
        det_q[2] <= red_det; // RL11
        det_q[1] <= yel_det;
      end
      if (end60) begin
        det_q[0] <= ais_det;
      end
    end
  end

  // Quick mode clears after two clean windows: a partial window plus two more stays inside the limit.
  assign red_clr = quick ? `TCAI_FAST_CLR_WIN : RED_CLR_WIN; // RL4 RL6
  assign ais_clr = quick ? `TCAI_FAST_CLR_WIN : AIS_CLR_WIN; // RL5 RL6

  // Frame loss alarm integrator.
  tcai_integ #(
    .CNT_W(INT_W)
  ) u_red (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_win_end(end40),
    .i_detect(red_det),
    .i_set_need(RED_SET_WIN),
    .i_clr_need(red_clr),
    .o_state_q(o_frame_loss_alarm_state)
  );

  // Remote alarm integrator.
  tcai_integ #(
    .CNT_W(INT_W)
  ) u_yel (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_win_end(end40),
    .i_detect(yel_det),
    .i_set_need(YEL_SET_WIN),
    .i_clr_need(YEL_CLR_WIN),
    .o_state_q(o_remote_alarm_state)
  );

  // All-ones alarm integrator.
  tcai_integ #(
    .CNT_W(INT_W)
  ) u_ais (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_win_end(end60),
    .i_detect(ais_det),
    .i_set_need(AIS_SET_WIN),
    .i_clr_need(ais_clr),
    .o_state_q(o_all_ones_alarm_state)
  );

  // Alarm states ordered as in the status register: remote, frame loss, all-ones.
  assign state = {o_remote_alarm_state, o_frame_loss_alarm_state, o_all_ones_alarm_state};
  assign change = state ^ prev_q;

  // AHB address phase decode.
  assign addr_act = i_hsel && i_hready && i_htrans[`TCAI_HTRANS_ACT];
  assign rd_act = addr_act && !i_hwrite;
  assign rd_idx = i_haddr[7:2];
  assign sts_read = rd_act && (rd_idx == `TCAI_IDX_STS);

  // A toggle in the same cycle as a status read still leaves its flag set.
  assign flag_d = (flag_q & ~{3{sts_read}}) | (change & irq_en); // RL7 RL8 RL9

  // Flags, previous states and the interrupt line.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q <= 3'h0;
      flag_q <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      prev_q <= state;
      flag_q <= flag_d; // RL8
      o_irq <= |flag_d; // RL15 RL9
    end
  end

  // Status view: sticky flags above, live states below.
  assign sts_view = {2'b00, flag_q, state}; // RL10

  // Read multiplexer; a write still in its data phase is forwarded so back-to-back access reads new data.
  always @* begin
    rd_byte = `TCAI_REG_RST;
    case (rd_idx)
      `TCAI_IDX_CFG: begin
        rd_byte = (wr_pend_q && wr_idx_q == `TCAI_IDX_CFG) ? {3'b000, i_hwdata[4:2], 2'b00} : cfg_q;
      end
      `TCAI_IDX_ENA: begin
        rd_byte = (wr_pend_q && wr_idx_q == `TCAI_IDX_ENA) ? {3'b000, i_hwdata[4:0]} : ena_q;
      end
      `TCAI_IDX_STS: begin
        rd_byte = sts_view;
      end
      `TCAI_IDX_DET: begin
        rd_byte = {5'b00000, det_q};
      end
      default: begin
        rd_byte = `TCAI_REG_RST;
      end
    endcase
  end

  // Bus slave: zero wait states, always OKAY, unmapped reads return zero and writes are dropped.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_q <= addr_act && i_hwrite;
      wr_idx_q <= rd_idx;
      if (rd_act) begin
        o_hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // Data phase write; reserved configuration bits are stored as written and never steer logic.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= `TCAI_REG_RST;
      ena_q <= `TCAI_REG_RST;
    end else if (wr_pend_q) begin
      if (wr_idx_q == `TCAI_IDX_CFG) begin
        cfg_q <= {3'b000, i_hwdata[`TCAI_CFG_FMT:`TCAI_CFG_RSV_LO], 2'b00}; // RL2
      end
      if (wr_idx_q == `TCAI_IDX_ENA) begin
        ena_q <= {3'b000, i_hwdata[`TCAI_ENA_QUICK:`TCAI_ENA_IRQ_LO]}; // RL7
      end
    end
  end

endmodule

// File: verilog/tcai_map.vh
// Register map, field positions and timing constants of the T1 carrier alarm integrator.
`ifndef TCAI_MAP_VH
`define TCAI_MAP_VH

// Register indices; the byte address is four times the index.
`define TCAI_IDX_CFG 6'h2C
`define TCAI_IDX_ENA 6'h2D
`define TCAI_IDX_STS 6'h2E
`define TCAI_IDX_DET 6'h2F

// Field positions in the format configuration register.
`define TCAI_CFG_FMT 4
`define TCAI_CFG_RSV_HI 3
`define TCAI_CFG_RSV_LO 2

// Field positions in the interrupt enable register.
`define TCAI_ENA_QUICK 4
`define TCAI_ENA_ACCELERATED_TEST_BIT 3
`define TCAI_ENA_IRQ_HI 2
`define TCAI_ENA_IRQ_LO 0

// Field positions in the interrupt status register.
`define TCAI_STS_FLAG_HI 5
`define TCAI_STS_FLAG_LO 3
`define TCAI_STS_STATE_HI 2
`define TCAI_STS_STATE_LO 0

// Reset value of every register bit.
`define TCAI_REG_RST 8'h00

// Window lengths and clock rate.
`define TCAI_WIN40_MS 40
`define TCAI_WIN60_MS 60
`define TCAI_CLK_KHZ 50000

// Detection thresholds.
`define TCAI_SF_YEL_MAX 5'h10
`define TCAI_ESF_YEL_MIN 4'h8
`define TCAI_AIS_ONES_MAX 7'h7E

// Windows needed to clear red or all-ones alarm in quick mode.
`define TCAI_FAST_CLR_WIN 4'h2

// Window shortening applied in production test mode.
`define TCAI_ACCELERATED_TEST_BIT_SHIFT 10

// AHB transfer type bit that marks an active transfer.
`define TCAI_HTRANS_ACT 1

`endif

// File: verilog/tcai_integ.v
// Window-by-window integrator that turns detection results into one alarm state.
`timescale 1ns/1ps
module tcai_integ #(
  parameter CNT_W = 4
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_resetn,
  // Window result.
  input wire i_win_end,
  input wire i_detect,
  // Consecutive windows needed to set and to clear.
  input wire [CNT_W-1:0] i_set_need,
  input wire [CNT_W-1:0] i_clr_need,
  // Integrated alarm.
  output reg o_state_q
);

  reg [CNT_W-1:0] run_q;
  wire [CNT_W-1:0] run_inc;
  wire [CNT_W-1:0] need;

  // A need of zero behaves as one window, so the alarm can never toggle outside a window end.
  assign run_inc = run_q + {{(CNT_W-1){1'b0}}, 1'b1};
  assign need = o_state_q ? i_clr_need : i_set_need;

  // Count windows that disagree with the present state; one agreeing window restarts the count.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q <= {CNT_W{1'b0}};
      o_state_q <= 1'b0;
    end else if (i_win_end) begin
      if (i_detect != o_state_q) begin
        if (run_inc >= need) begin
          o_state_q <= ~o_state_q; // RL16
          run_q <= {CNT_W{1'b0}};
        end else begin
          run_q <= run_inc;
        end
      end else begin
        run_q <= {CNT_W{1'b0}};
      end
    end
  end

endmodule

// File: testbench/tcai_alarm_integrator_checker.sv
// Port-level assertions for the carrier alarm integrator.
`timescale 1ns/1ps
module tcai_alarm_integrator_checker #(
  parameter WIN40_CYC = 400
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_resetn,
  // Register bus.
  input wire i_hsel,
  input wire [7:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  // Framer and alarms.
  input wire i_out_of_frame,
  input wire o_remote_alarm_state,
  input wire o_frame_loss_alarm_state,
  input wire o_all_ones_alarm_state,
  input wire o_irq
);
  // Taken reads, and the alarm states as one vector.
  wire rd_any = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  wire rd_sts = rd_any && i_haddr[7:2] == 6'h2E;
  wire [2:0] st = {o_remote_alarm_state, o_frame_loss_alarm_state, o_all_ones_alarm_state};
  reg [31:0] wc_q;
  // Own copy of the free running short window, so alarm moves can be tied to window ends.
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wc_q <= 32'h0;
    end else if (wc_q == WIN40_CYC - 1) begin
      wc_q <= 32'h0;
    end else begin
      wc_q <= wc_q + 32'h1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready or not okay");
  rdata_stand_a: assert property (!rd_any |=> $stable(o_hrdata)) else $error("read data moved without a read");
  irq_cause_a: assert property ($rose(o_irq) |-> $past(st) != $past(st, 2)) else $error("irq without toggle");
  irq_hold_a: assert property ($fell(o_irq) |-> $past(rd_sts)) else $error("irq dropped without read");
  read_clear_a: assert property (rd_sts && $stable(st) ##1 $stable(st) |=> !o_irq)
    else $error("status read left irq set");
  short_window_a: assert property ($changed(st[2:1]) |-> wc_q < 4)
    else $error("red or yellow moved off a window end");
  ones_oof_a: assert property ($rose(o_all_ones_alarm_state) |-> $past(i_out_of_frame, 3))
    else $error("all ones alarm while in frame");
  rdata_upper_a: assert property (o_hrdata[31:8] == 24'h0) else $error("upper read data not zero");
endmodule

bind tcai_alarm_integrator tcai_alarm_integrator_checker #(.WIN40_CYC(WIN40_CYC)) chk (.i_sys_clk, .i_resetn,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_out_of_frame,
  .o_remote_alarm_state, .o_frame_loss_alarm_state, .o_all_ones_alarm_state, .o_irq);

// File: testbench/tcai_framer_model.sv
// Behavioural receive framer feeding frame state and line bits.
`timescale 1ns/1ps
module tcai_framer_model (
  // Clock and scenario controls.
  input wire i_sys_clk,
  input wire [3:0] i_mode,
  input wire i_noise,
  // Framer indications.
  output reg o_oof = 1'b0,
  output reg o_pcm_valid = 1'b0,
  output reg o_pcm_bit = 1'b0,
  output reg o_b2_valid = 1'b0,
  output reg o_b2 = 1'b0,
  output reg o_code_ok = 1'b0
);
  reg [3:0] cnt_q = 4'h0;
  // Mode bits: out of frame, PCM ones, channel bit value, yellow codes.
  // Between strobes the bit line keeps moving, so a stale value is never taken for data.
  always @(posedge i_sys_clk) begin
    cnt_q <= cnt_q + 4'h1;
    o_oof <= i_mode[3];
    o_pcm_valid <= 1'b1;
    o_pcm_bit <= i_mode[2] & (i_noise | cnt_q[0]);
    o_b2_valid <= cnt_q[1:0] == 2'h0;
    o_b2 <= (cnt_q[1:0] == 2'h0) ? i_mode[1] : cnt_q[2];
    o_code_ok <= i_mode[0] & (cnt_q == 4'hF);
  end
endmodule

// File: testbench/test_tcai_alarm_integrator.sv
// Self-checking bench for the carrier alarm integrator.
`timescale 1ns/1ps
module test_tcai_alarm_integrator;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] mode = 4'h6;
  logic [15:0] lf = 16'hFF53;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [2:0] st = 3'h0;
  logic [2:0] fl;
  // Alarm pins as one vector: remote, frame loss, all-ones.
  wire [2:0] pins;
  logic [11:0] s;
  logic rdy, irq, out_of_frame, pv, pb, bv, bb, yc;
  int miscompares = 0;
  int n_tests = 0;
  int ncyc = 0;
  // Steps: mode, format, quick clear, enables, expected alarm states.
  logic [11:0] stp [13] = '{12'h638, 12'hE1A, 12'h668, 12'hA33, 12'h648, 12'hE12, 12'h612,
    12'h610, 12'h424, 12'h4A0, 12'h584, 12'h7A4, 12'h720};
  int cyc [13] = '{1300, 2000, 1204, 2500, 1804, 2000, 1204, 1700, 1300, 1300, 1300, 1300, 1300};

  tcai_alarm_integrator #(.WIN40_CYC(400), .WIN60_CYC(600)) uut (.i_sys_clk(clk), .i_resetn(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(), .i_out_of_frame(out_of_frame), .i_pcm_valid(pv),
    .i_pcm_bit(pb), .i_chan_bit2_valid(bv), .i_chan_bit2(bb), .i_yellow_code_ok(yc),
    .o_remote_alarm_state(pins[2]), .o_frame_loss_alarm_state(pins[1]), .o_all_ones_alarm_state(pins[0]),
    .o_irq(irq));
  tcai_framer_model fr (.i_sys_clk(clk), .i_mode(mode), .i_noise(lf[0]), .o_oof(out_of_frame), .o_pcm_valid(pv),
    .o_pcm_bit(pb), .o_b2_valid(bv), .o_b2(bb), .o_code_ok(yc));

  // Next state of the bench's random source.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Clock, random line noise and the hang limit.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    lf <= lfsr_next(lf);
    ncyc++;
    if (ncyc == 40000) begin
      miscompares++;
      final_report;
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single word transfer; the slave's ready decides every wait.
  task bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 6'h2C; a < 6'h31; a++) begin
      bus(0, a[5:0], 0);
      chk("reset value", 0, rd);
    end
    bus(1, 6'h2C, 32'h10);
    bus(0, 6'h2C, 0);
    chk("config", 32'h10, rd);
    bus(1, 6'h3A, 32'hFF);
    bus(0, 6'h3A, 0);
    chk("unmapped", 0, rd);
    // The random source moves every clock, so the written value is captured before the write.
    s = {7'h00, lf[4], 1'b0, lf[2:0]};
    bus(1, 6'h2D, {27'h0, s[4:0]});
    bus(0, 6'h2D, 0);
    chk("enable", s, rd);
    // Each step holds one line condition long enough to settle, except stp[6], which ends before the standard red clear,
    // then audits the pins, the interrupt, the status and detect registers.
    for (int i = 0; i < 13; i++) begin
      s = stp[i];
      bus(1, 6'h2C, {27'h0, s[7], 4'h0});
      bus(1, 6'h2D, {27'h0, s[6], 1'b0, s[5:3]});
      mode <= s[11:8];
      repeat (cyc[i]) @(posedge clk);
      fl = (st ^ s[2:0]) & s[5:3];
      chk("irq", |fl, irq);
      chk("alarm pins", s[2:0], pins);
      bus(0, 6'h2E, 0);
      chk("status", {fl, s[2:0]}, rd);
      bus(0, 6'h2E, 0);
      chk("status again", s[2:0], rd);
      chk("irq cleared", 0, irq);
      bus(0, 6'h2F, 0);
      chk("detect", {s[11], s[7] ? s[8] : !s[9], s[11] & !s[10]}, rd);
      st = s[2:0];
    end
    final_report;
  end
endmodule
